// ### hw/alarm_pkg.sv
package alarm_pkg;

   localparam int unsigned ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MASK      = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SUMMARY   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PIN_CFG   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_OSC_SYNC  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h20;

   // Alarm bit positions
   localparam int unsigned NUM_ALM     = 5;
   localparam int unsigned BIT_PLL     = 0;
   localparam int unsigned BIT_LINK    = 1;
   localparam int unsigned BIT_REALIGN = 2;
   localparam int unsigned BIT_OSC     = 3;
   localparam int unsigned BIT_CLOCK   = 4;

   // Reset values
   localparam logic [NUM_ALM-1:0] RST_MASK   = 5'h1f;
   localparam logic               RST_PINSEL = 1'b0;
   localparam logic               RST_LINKEN = 1'b0;
   localparam logic               RST_SYNSEL = 1'b0;
   localparam logic [NUM_ALM-1:0] RST_IRQEN  = 5'h00;

   localparam int unsigned ACC_W = 32;
   localparam int unsigned NUM_OSC = 4;

   // Oscillator synchronisation state
   typedef enum logic [1:0] {
      SYNC_WAIT = 2'b01,
      SYNC_DONE = 2'b10
   } sync_state_t;

endpackage

// ### hw/alarm_cmp_if.sv
`timescale 1ns/1ps
interface alarm_cmp_if;
   import alarm_pkg::*;
   logic                           check_en;
   logic [NUM_OSC-1:0][ACC_W-1:0]  acc_a;
   logic [NUM_OSC-1:0][ACC_W-1:0]  acc_b;
   logic                           mismatch;
   modport cmp (input check_en, input acc_a, input acc_b, output mismatch);
   modport top (output check_en, output acc_a, output acc_b, input mismatch);
endinterface

// ### hw/osc_compare.sv
`timescale 1ns/1ps
module osc_compare (
   input  wire logic     mclk_i,
   input  wire logic     rst_b_i,
   alarm_cmp_if.cmp      cmp
);
   import alarm_pkg::*;

   logic mismatch_ff;

   // Registered so a one-cycle glitch is still caught as a full pulse
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mismatch_ff <= 1'b0;
      end else begin
         mismatch_ff <= cmp.check_en && (cmp.acc_a != cmp.acc_b); // [R5]
      end
   end

   assign cmp.mismatch = mismatch_ff;
endmodule // osc_compare

// ### hw/alarm_upset_monitor.sv
// Behaviour
// [R1] Five alarm events are watched: PLL unlock, link out of data state, SYSREF realign, oscillator upset, clock upset.
// [R2] Each event sets its own sticky status bit, cleared only by writing one to it.
// [R3] Unmasked status bits feed the summary alarm; masked ones do not.
// [R4] With pin select on alarm, the status pin goes high while any alarm is shown.
// [R5] Channel A and B oscillator accumulators are compared every cycle; one mismatch cycle sets the oscillator flag.
// [R6] Oscillator comparison only counts after synchronisation by SYSREF or lane alignment start, per the sync setting.
// [R7] Software must load matching phase and frequency words into both channels at each index.
// [R8] Channel B may select another oscillator via its select pins, halving hopping choices.
// [R9] Software follows the arm sequence: link off, power both, mode, words, link on, sync, clear, monitor.
// [R10] After word changes or power-down exit, software resyncs, clears and monitors again.
// [R11] Channel A and B half-rate clocks are compared; one differing half-rate cycle sets the clock flag.
// [R12] Software arms clock detection by link off, powering both channels, link on, then clear.
// [R13] After power-down exit the clock flag may be set and software clears it first.
// [R14] With link enable low the link block is held in reset, serializers off, clocks gated.
// [R15] Writing zero leaves a status bit alone, and a set in the clearing cycle wins.
`timescale 1ns/1ps
module alarm_upset_monitor (
   input  wire logic                                     mclk_i,
   input  wire logic                                     rst_b_i,
   input  wire logic                                     hsel_i,
   input  wire logic [31:0]                              haddr_i,
   input  wire logic [1:0]                               htrans_i,
   input  wire logic                                     hwrite_i,
   input  wire logic [2:0]                               hsize_i,
   input  wire logic [31:0]                              hwdata_i,
   input  wire logic                                     hready_i,
   output logic [31:0]                                   hrdata_o,
   output logic                                          hreadyout_o,
   output logic                                          hresp_o,
   input  wire logic                                     pll_locked_i,
   input  wire logic                                     link_in_data_i,
   input  wire logic                                     sysref_realign_i,
   input  wire logic                                     sysref_sync_i,
   input  wire logic                                     lane_align_start_i,
   input  wire logic [alarm_pkg::NUM_OSC-1:0][alarm_pkg::ACC_W-1:0] chan_a_acc_i,
   input  wire logic [alarm_pkg::NUM_OSC-1:0][alarm_pkg::ACC_W-1:0] chan_b_acc_i,
   input  wire logic                                     chan_a_half_clk_i,
   input  wire logic                                     chan_b_half_clk_i,
   input  wire logic                                     calib_status_i,
   output logic                                          cal_status_out_pin_o,
   output logic                                          summary_alarm_o,
   output logic                                          link_reset_b_o,
   output logic                                          serializer_pwr_o,
   output logic                                          link_clk_en_o,
   output logic                                          irq_o
);
   import alarm_pkg::*;

   alarm_cmp_if cmp_if ();

   logic                   wr_pend_ff;
   logic [ADDR_W-1:0]      addr_ff;
   logic [NUM_ALM-1:0]     alarm_status_bits_ff;
   logic [NUM_ALM-1:0]     mask_ff;
   logic [NUM_ALM-1:0]     irq_en_ff;
   logic [NUM_ALM-1:0]     irq_stat_ff;
   logic                   pin_sel_ff;
   logic                   link_interface_enable_ff;
   logic                   sync_src_ff;
   logic                   half_phase_ff;
   sync_state_t            sync_ff;
   logic [NUM_ALM-1:0]     event_set;
   logic [NUM_ALM-1:0]     wr_clear;
   logic [NUM_ALM-1:0]     irq_clear;
   logic                   clk_diff;
   logic                   sync_pulse;
   logic [31:0]            nxt_hrdata;
   logic                   take;

   function automatic logic is_write(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs,
                                     input logic pend, input logic [ADDR_W-1:0] cur);
      return pend && (cur == a) && (a == ofs);
   endfunction

   // Address phase capture; zero wait states
   assign take = hsel_i && hready_i && htrans_i[1];

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_pend_ff <= 1'b0;
         addr_ff    <= '0;
      end else if (hready_i) begin
         wr_pend_ff <= take && hwrite_i;
         addr_ff    <= haddr_i[ADDR_W-1:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // Control registers written in the data phase
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_ff                  <= RST_MASK;
         pin_sel_ff               <= RST_PINSEL;
         link_interface_enable_ff <= RST_LINKEN;
         sync_src_ff              <= RST_SYNSEL;
         irq_en_ff                <= RST_IRQEN;
      end else if (wr_pend_ff) begin
         case (addr_ff)
            OFS_MASK:      mask_ff                  <= hwdata_i[NUM_ALM-1:0];
            OFS_PIN_CFG:   pin_sel_ff               <= hwdata_i[0];
            OFS_LINK_CTRL: link_interface_enable_ff <= hwdata_i[0];
            OFS_OSC_SYNC:  sync_src_ff              <= hwdata_i[0];
            OFS_IRQ_EN:    irq_en_ff                <= hwdata_i[NUM_ALM-1:0];
            default:       ;
         endcase
      end
   end

   // Link block control follows enable one cycle later
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_reset_b_o   <= 1'b0;
         serializer_pwr_o <= 1'b0;
         link_clk_en_o    <= 1'b0;
      end else begin
         link_reset_b_o   <= link_interface_enable_ff; // [R14]
         serializer_pwr_o <= link_interface_enable_ff; // [R14]
         link_clk_en_o    <= link_interface_enable_ff; // [R14]
      end
   end

   // Sync qualifier: source 0 = SYSREF, 1 = lane alignment start
   assign sync_pulse = sync_src_ff ? lane_align_start_i : sysref_sync_i; // [R6]

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_ff <= SYNC_WAIT;
      end else begin
         case (sync_ff)
            SYNC_WAIT: if (sync_pulse) sync_ff <= SYNC_DONE; // [R6]
            SYNC_DONE: if (!link_interface_enable_ff) sync_ff <= SYNC_WAIT;
            default:   sync_ff <= SYNC_WAIT;
         endcase
      end
   end

   assign cmp_if.check_en = (sync_ff == SYNC_DONE) && link_interface_enable_ff; // [R6]
   assign cmp_if.acc_a    = chan_a_acc_i;
   assign cmp_if.acc_b    = chan_b_acc_i;

   osc_compare u_cmp (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .cmp     (cmp_if.cmp)
   );

   // Half-rate sampling of clock compare; inputs are sampled only on half-rate phases
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         half_phase_ff <= 1'b0;
      end else begin
         half_phase_ff <= !half_phase_ff;
      end
   end

   assign clk_diff = half_phase_ff && (chan_a_half_clk_i != chan_b_half_clk_i); // [R11]

   always_comb begin
      event_set              = '0;
      event_set[BIT_PLL]     = !pll_locked_i && link_interface_enable_ff; // [R1]
      event_set[BIT_LINK]    = !link_in_data_i && link_interface_enable_ff; // [R1]
      event_set[BIT_REALIGN] = sysref_realign_i; // [R1]
      event_set[BIT_OSC]     = cmp_if.mismatch; // [R5]
      event_set[BIT_CLOCK]   = clk_diff; // [R11]
   end

   assign wr_clear  = (wr_pend_ff && addr_ff == OFS_STATUS) ? hwdata_i[NUM_ALM-1:0] : '0;
   assign irq_clear = is_write(addr_ff, OFS_IRQ_CLR, wr_pend_ff, addr_ff) ?
                      hwdata_i[NUM_ALM-1:0] : '0;

   // Set beats clear in the same cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         alarm_status_bits_ff <= '0;
      end else begin
         alarm_status_bits_ff <= (alarm_status_bits_ff & ~wr_clear) | event_set; // [R2] [R15]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clear) | event_set;
      end
   end

   // Outputs one cycle behind the flags
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         summary_alarm_o      <= 1'b0;
         cal_status_out_pin_o <= 1'b0;
         irq_o                <= 1'b0;
      end else begin
         summary_alarm_o      <= |(alarm_status_bits_ff & ~mask_ff); // [R3]
         cal_status_out_pin_o <= pin_sel_ff ? |(alarm_status_bits_ff & ~mask_ff) // [R4]
                                            : calib_status_i;
         irq_o                <= |(irq_stat_ff & irq_en_ff);
      end
   end

   // Limitation: a read right behind a write to the same register returns the old value
   always_comb begin
      nxt_hrdata = '0;
      case (haddr_i[ADDR_W-1:0])
         OFS_STATUS:    nxt_hrdata[NUM_ALM-1:0] = alarm_status_bits_ff;
         OFS_MASK:      nxt_hrdata[NUM_ALM-1:0] = mask_ff;
         OFS_SUMMARY:   nxt_hrdata[0]           = |(alarm_status_bits_ff & ~mask_ff);
         OFS_PIN_CFG:   nxt_hrdata[0]           = pin_sel_ff;
         OFS_LINK_CTRL: nxt_hrdata[0]           = link_interface_enable_ff;
         OFS_OSC_SYNC:  nxt_hrdata[1:0]         = {sync_ff == SYNC_DONE, sync_src_ff};
         OFS_IRQ_EN:    nxt_hrdata[NUM_ALM-1:0] = irq_en_ff;
         OFS_IRQ_STAT:  nxt_hrdata[NUM_ALM-1:0] = irq_stat_ff;
         default:       nxt_hrdata              = '0;
      endcase
   end

   // Read data registered at the address-phase edge so it stands in the data phase
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hrdata_o <= '0;
      end else if (take && !hwrite_i) begin
         hrdata_o <= nxt_hrdata;
      end
   end

endmodule // alarm_upset_monitor

// ### sim/alarm_upset_monitor_properties.sv
`timescale 1ns/1ps
module alarm_upset_monitor_properties (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic        hready_i,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        pll_locked_i,
   input wire logic        link_in_data_i,
   input wire logic        sysref_realign_i,
   input wire logic [alarm_pkg::NUM_OSC-1:0][alarm_pkg::ACC_W-1:0] chan_a_acc_i,
   input wire logic [alarm_pkg::NUM_OSC-1:0][alarm_pkg::ACC_W-1:0] chan_b_acc_i,
   input wire logic        chan_a_half_clk_i,
   input wire logic        chan_b_half_clk_i,
   input wire logic        calib_status_i,
   input wire logic        cal_status_out_pin_o,
   input wire logic        summary_alarm_o,
   input wire logic        link_reset_b_o,
   input wire logic        serializer_pwr_o,
   input wire logic        link_clk_en_o,
   input wire logic        irq_o
);
   import alarm_pkg::*;
   logic       wr_any;
   logic       wr_link;
   logic       ev_any;
   logic [3:0] wr_age_ff;
   logic [3:0] ev_age_ff;
   assign wr_any  = hsel_i && hready_i && htrans_i[1] && hwrite_i;
   assign wr_link = wr_any && haddr_i[7:0] == OFS_LINK_CTRL;
   assign ev_any  = !pll_locked_i || !link_in_data_i || sysref_realign_i ||
                    chan_a_acc_i != chan_b_acc_i || chan_a_half_clk_i != chan_b_half_clk_i;
   // Ages saturate so an old cause never excuses a late output change
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) wr_age_ff <= 4'hf;
      else wr_age_ff <= wr_any ? 4'h0 : wr_age_ff + {3'h0, wr_age_ff != 4'hf};
   end
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) ev_age_ff <= 4'hf;
      else ev_age_ff <= ev_any ? 4'h0 : ev_age_ff + {3'h0, ev_age_ff != 4'hf};
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_quiet;
      !wr_any [*6];
   endsequence
   AST_OKAY: assert property (hresp_o == 1'h0 && hreadyout_o == 1'h1)
      else $error("bus answer not okay");
   AST_LINK_COPIES: assert property (link_reset_b_o == serializer_pwr_o &&
      link_reset_b_o == link_clk_en_o)
      else $error("link controls disagree");
   AST_LINK_CAUSE: assert property ($changed(link_reset_b_o) |-> $past(wr_link, 2) ||
      $past(wr_link, 3) || $past(wr_link, 4))
      else $error("link control moved without a write");
   AST_SUM_FALL: assert property ($fell(summary_alarm_o) |-> wr_age_ff <= 4'h5)
      else $error("summary dropped without a write");
   AST_SUM_RISE: assert property ($rose(summary_alarm_o) |-> ev_age_ff <= 4'h6 ||
      wr_age_ff <= 4'h5)
      else $error("summary rose without a cause");
   AST_IRQ_HOLD: assert property (s_quiet ##0 irq_o |=> irq_o)
      else $error("interrupt dropped without a write");
   AST_IRQ_RISE: assert property ($rose(irq_o) |-> ev_age_ff <= 4'h6 ||
      wr_age_ff <= 4'h5)
      else $error("interrupt rose without a cause");
   AST_PIN_RISE: assert property ($rose(cal_status_out_pin_o) |-> $past(calib_status_i) ||
      $past(calib_status_i, 2) || ev_age_ff <= 4'h6 || wr_age_ff <= 4'h5)
      else $error("status pin rose without a cause");
endmodule // alarm_upset_monitor_properties
bind alarm_upset_monitor alarm_upset_monitor_properties i_alarm_upset_monitor_properties (
   .mclk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o,
   .hresp_o, .pll_locked_i, .link_in_data_i, .sysref_realign_i, .chan_a_acc_i, .chan_b_acc_i,
   .chan_a_half_clk_i, .chan_b_half_clk_i, .calib_status_i, .cal_status_out_pin_o,
   .summary_alarm_o, .link_reset_b_o, .serializer_pwr_o, .link_clk_en_o, .irq_o);

// ### sim/alarm_upset_monitor_bench.sv
`timescale 1ns/1ps
module alarm_upset_monitor_bench;
   import alarm_pkg::*;
   logic        mclk_i = 1'h0, rst_b_i = 1'h0, hsel_i = 1'h0, hwrite_i = 1'h0, glitch = 1'h0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
   logic [1:0]  htrans_i = 2'h0;
   logic        pll_locked_i = 1'h1, link_in_data_i = 1'h1, sysref_realign_i = 1'h0;
   logic        sysref_sync_i = 1'h0, lane_align_start_i = 1'h0, calib_status_i = 1'h0;
   logic        chan_a_half_clk_i = 1'h0, chan_b_half_clk_i = 1'h0;
   logic [NUM_OSC-1:0][ACC_W-1:0] chan_a_acc_i = '0, chan_b_acc_i = '0;
   logic        hreadyout_o, hresp_o, cal_status_out_pin_o, summary_alarm_o, irq_o;
   logic        link_reset_b_o, serializer_pwr_o, link_clk_en_o;
   int          n_errors = 0, n_compared = 0, st = 0, irqs = 0, mask = 31, ien = 0, sel = 0;
   logic [7:0]  ofs [9] = '{OFS_STATUS, OFS_MASK, OFS_SUMMARY, OFS_PIN_CFG, OFS_LINK_CTRL,
                            OFS_OSC_SYNC, OFS_IRQ_EN, OFS_IRQ_STAT, 8'h40};
   logic [31:0] rst_val [9] = '{32'h0, 32'h1f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   alarm_upset_monitor i_alarm_upset_monitor (
      .mclk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
      .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .pll_locked_i, .link_in_data_i,
      .sysref_realign_i, .sysref_sync_i, .lane_align_start_i, .chan_a_acc_i, .chan_b_acc_i,
      .chan_a_half_clk_i, .chan_b_half_clk_i, .calib_status_i, .cal_status_out_pin_o,
      .summary_alarm_o, .link_reset_b_o, .serializer_pwr_o, .link_clk_en_o, .irq_o);
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   // Channel B half clock tracks A unless a glitch is injected
   always @(posedge mclk_i) begin
      chan_a_half_clk_i <= ~chan_a_half_clk_i;
      chan_b_half_clk_i <= ~chan_a_half_clk_i ^ glitch;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic edge_ready();
      int n;
      n = 0;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'h1) begin
         n++;
         if (n > 64) begin
            n_errors++;
            tally_and_finish();
         end
         @(posedge mclk_i);
      end
   endtask
   // Read data stands through the data phase and is taken at its closing edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic pulse, output logic [31:0] rd);
      hsel_i <= 1'h1;
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      haddr_i <= {24'h0, a};
      edge_ready();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      sysref_realign_i <= pulse;
      edge_ready();
      rd = hrdata_o;
      sysref_realign_i <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'h1, a, d, 1'h0, x);
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'h0, a, 32'h0, 1'h0, x);
      check(what, x, exp);
   endtask
   task automatic check_all();
      rdc("status", OFS_STATUS, st);
      rdc("irq status", OFS_IRQ_STAT, irqs);
      check("summary", summary_alarm_o, (st & ~mask) != 0);
      check("irq", irq_o, (irqs & ien) != 0);
      check("pin", cal_status_out_pin_o, sel ? (st & ~mask) != 0 : calib_status_i);
   endtask
   task automatic fire(input int b, input bit hit);
      case (b)
         BIT_PLL:     pll_locked_i <= 1'h0;
         BIT_LINK:    link_in_data_i <= 1'h0;
         BIT_REALIGN: sysref_realign_i <= 1'h1;
         BIT_OSC:     chan_b_acc_i <= ~chan_a_acc_i;
         default:     glitch <= 1'h1;
      endcase
      repeat (b == BIT_CLOCK ? 2 : 1) @(posedge mclk_i);
      pll_locked_i <= 1'h1;
      link_in_data_i <= 1'h1;
      sysref_realign_i <= 1'h0;
      chan_b_acc_i <= chan_a_acc_i;
      glitch <= 1'h0;
      repeat (6) @(posedge mclk_i);
      if (hit) begin
         st |= 1 << b;
         irqs |= 1 << b;
      end
   endtask
   task automatic sync_pulse(input int lane);
      if (lane != 0) lane_align_start_i <= 1'h1;
      else sysref_sync_i <= 1'h1;
      @(posedge mclk_i);
      lane_align_start_i <= 1'h0;
      sysref_sync_i <= 1'h0;
   endtask
   initial begin
      logic [127:0] r;
      logic [31:0]  x;
      int           c;
      void'($urandom(32'h949c07a4));
      r = {$urandom(), $urandom(), $urandom(), $urandom()};
      chan_a_acc_i <= r;
      chan_b_acc_i <= r;
      repeat (16) @(posedge mclk_i);
      rst_b_i <= 1'h1;
      for (int i = 0; i < 9; i++) rdc("reset value", ofs[i], rst_val[i]);
      check("link off", {link_reset_b_o, serializer_pwr_o, link_clk_en_o}, 0);
      mask = 0;
      wr(OFS_MASK, 0);
      fire(BIT_PLL, 0);
      fire(BIT_LINK, 0);
      wr(OFS_LINK_CTRL, 1);
      repeat (3) @(posedge mclk_i);
      check("link on", {link_reset_b_o, serializer_pwr_o, link_clk_en_o}, 7);
      fire(BIT_OSC, 0);
      check_all();
      for (int s = 0; s < 2; s++) begin
         wr(OFS_LINK_CTRL, 0);
         wr(OFS_LINK_CTRL, 1);
         wr(OFS_OSC_SYNC, s);
         sync_pulse(1 - s);
         rdc("unsynced", OFS_OSC_SYNC, s);
         sync_pulse(s);
         rdc("synced", OFS_OSC_SYNC, s + 2);
      end
      for (int b = 0; b < NUM_ALM; b++) fire(b, 1);
      check_all();
      repeat (8) begin
         mask = $urandom & 31;
         ien = $urandom & 31;
         sel = $urandom & 1;
         calib_status_i <= 1'($urandom);
         wr(OFS_MASK, mask);
         wr(OFS_IRQ_EN, ien);
         wr(OFS_PIN_CFG, sel);
         check_all();
         c = $urandom & 31;
         wr(OFS_STATUS, c);
         wr(OFS_IRQ_CLR, c);
         st &= ~c;
         irqs &= ~c;
         check_all();
         fire($urandom % 5, 1);
      end
      bus(1'h1, OFS_STATUS, 32'h1f, 1'h1, x);
      st = 4;
      irqs |= 4;
      check_all();
      tally_and_finish();
   end
endmodule // alarm_upset_monitor_bench
